// *** rtl/fpsm_pkg.sv ***
// shared constants, types and carriers of the front-panel settings menu
package fpsm_pkg;
    // clock and tick base
    localparam int CLK_NS = 50;
    localparam int TICK_US = 10000;
    localparam int TICK_MS = TICK_US / 1000;
    localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
    // button timing in milliseconds, option timeout in seconds, and the derived tick counts
    localparam int EXIT_HOLD_MS = 1000;
    localparam int RESET_HOLD_MS = 3000;
    localparam int COUNT_STEP_MS = 1000;
    localparam int REP_DLY_MS = 300;
    localparam int REP_FAST_MS = 100;
    localparam int OPT2_TIMEOUT_S = 900;
    localparam int EXIT_TICKS = EXIT_HOLD_MS / TICK_MS;
    localparam int RESET_TICKS = RESET_HOLD_MS / TICK_MS;
    localparam int STEP_TICKS = COUNT_STEP_MS / TICK_MS;
    localparam int REP_DLY_TICKS = REP_DLY_MS / TICK_MS;
    localparam int REP_FAST_TICKS = REP_FAST_MS / TICK_MS;
    localparam int OPT2_TICKS = OPT2_TIMEOUT_S * 1000 / TICK_MS;
    localparam logic [2:0] COUNT_START = 3'h5;
    // value ranges and factory defaults
    localparam logic [3:0] FREQ_MIN = 4'h1;
    localparam logic [3:0] FREQ_MAX = 4'h8;
    localparam logic [3:0] SENS_OFF = 4'h0;
    localparam logic [3:0] SENS_CALL = 4'hA;
    localparam logic [7:0] DELAY_MAX = 8'hFF;
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SET = 8'h04;
    localparam logic [7:0] ADDR_MENU = 8'h08;
    localparam int CTRL_RESET_BIT = 0;

    typedef enum logic [1:0] {ST_NORMAL, ST_PROG, ST_RESTORE} fpsm_state_e;
    typedef enum logic [2:0] {P_FREQ, P_SENS, P_MODE, P_DELAY, P_EOG, P_OPT1, P_OPT2, P_OPT3} fpsm_param_e;

    typedef struct packed {
        logic [3:0] freq;
        logic [3:0] sens;
        logic pulse_mode;
        logic [7:0] delay_s;
        logic end_of_green_hold;
        logic opt1;
        logic opt2;
        logic opt3;
    } fpsm_set_s;

    localparam fpsm_set_s SET_DEF = '{freq: 4'h2, sens: 4'h6, pulse_mode: 1'b0, delay_s: 8'h00,
                                      end_of_green_hold: 1'b0, opt1: 1'b0, opt2: 1'b0, opt3: 1'b0};

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } fpsm_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fpsm_apb_rsp_s;

    typedef struct packed {
        logic prog;
        logic [2:0] param;
        logic seg_blank;
        logic [15:0] seg_val;
        logic [7:0] bar;
    } fpsm_disp_s;
endpackage : fpsm_pkg

// *** rtl/fpsm_top.sv ***
// front-panel settings menu: buttons, menu states, live settings, apb status
//
// Operation
// - all three buttons held: count down from five, once per second
// - release after countdown hits zero: load factory defaults, then detector reset
// - detection keeps running while the menu is in programming state
// - the shown value is the live value used by detection, except a deferred mode or delay change
// - function-select press in normal state enters programming state
// - function-select auto-repeats, advancing forward only
// - holding up or down steps the value repeatedly at fast rate
// - function-select held one second in programming returns to normal
// - frequency 1 to 8, bargraph left to right, default 2
// - frequency view shows measured loop frequency, tenths of kilohertz
// - sensitivity off, 1 to 9, call; default 6
// - sensitivity view: bargraph shows call signal strength
// - presence or pulse mode, default presence, seven-segment blanked
// - mode change during a call waits for empty zone or reset
// - delay held in whole seconds, default zero
// - delay change with zone occupied waits for empty zone or reset
// - end-of-green and options 1 to 3 on/off, default off
// - inductance-change display option clears fifteen minutes after switching on
// - function-select held three seconds in normal, or frequency/sensitivity change, resets
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
module fpsm_top #(
    parameter int TICK_CYC = fpsm_pkg::TICK_CYC,
    parameter int OPT2_TICKS = fpsm_pkg::OPT2_TICKS
) (
    input wire logic ref_clk,                              // 20 MHz clock
    input wire logic reset,                                // synchronous reset, high
    input wire fpsm_pkg::fpsm_apb_req_s apb_req,           // apb request
    output fpsm_pkg::fpsm_apb_rsp_s apb_rsp,               // apb answer
    input wire logic btn_function_select_button_pin,                         // function-select button, high pressed
    input wire logic btn_up_pin,                           // up button, high pressed
    input wire logic btn_down_pin,                         // down button, high pressed
    input wire logic zone_occupied,                        // detection zone occupied or call active
    input wire logic [7:0] call_strength,                  // vehicle call strength bargraph
    input wire logic [15:0] freq_meas_bcd,                 // measured loop frequency, bcd tenths
    output fpsm_pkg::fpsm_set_s live_set,                  // settings used by detection
    output logic det_reset,                                // detector reset pulse
    output fpsm_pkg::fpsm_disp_s disp                      // display contents
);
    logic [2:0] btn_m_r, btn_s_r, btn_q_r, count_r;
    logic [17:0] tick_cnt_r;
    logic [16:0] function_select_button_hold_r, step_cnt_r, opt2_cnt_r;
    logic [7:0] function_select_button_rep_r, ud_rep_r, delay_eff_r;
    logic [8:0] function_select_button_rep_nxt, ud_rep_nxt;
    fpsm_pkg::fpsm_state_e state_r;
    fpsm_pkg::fpsm_param_e param_r;
    fpsm_pkg::fpsm_set_s set_r, set_nxt;
    logic [31:0] prdata_r;
    fpsm_pkg::fpsm_disp_s disp_r;
    logic tick, function_select_button_used_r, mode_eff_r, det_reset_r, sw_reset_r;
    logic function_select_button_on, all3, none_on, function_select_button_edge, function_select_button_rel, adv, exit_hit, hold_reset;
    logic up_step, dn_step, restore_fire, opt2_expire, apb_wr, addr_ok;
    // auto-repeat: first step on press, then after a delay at the fast rate
    function automatic logic [8:0] rep_next(input logic held, input logic edge_in, input logic tk,
                                            input logic [7:0] cnt);
        logic [8:0] r;
        r = {1'b0, cnt};
        if (!held || edge_in)
            r = {1'b0, 8'(fpsm_pkg::REP_DLY_TICKS - 1)};
        else if (tk && cnt == 8'h00)
            r = {1'b1, 8'(fpsm_pkg::REP_FAST_TICKS - 1)};
        else if (tk)
            r = {1'b0, cnt - 8'h01};
        return r;
    endfunction : rep_next

    // pins cross into the clock domain over two flip-flops
    always_ff @(posedge ref_clk)
    begin
        btn_m_r <= reset ? 3'h0 : {btn_down_pin, btn_up_pin, btn_function_select_button_pin};
        btn_s_r <= reset ? 3'h0 : btn_m_r;
        btn_q_r <= reset ? 3'h0 : btn_s_r;
    end

    assign function_select_button_on = btn_s_r[0];
    assign all3 = &btn_s_r;
    assign none_on = ~|btn_s_r;
    assign function_select_button_edge = btn_s_r[0] & ~btn_q_r[0];
    assign function_select_button_rel = ~btn_s_r[0] & btn_q_r[0];
    assign tick = (tick_cnt_r == 18'(TICK_CYC - 1));

    // 10 ms time base shared by all hold and repeat timers
    always_ff @(posedge ref_clk)
    begin
        if (reset || tick)
            tick_cnt_r <= 18'h00000;
        else
            tick_cnt_r <= tick_cnt_r + 18'h00001;
    end

    // function-select hold and repeat timers; a hold that already acted suppresses its release
    always_ff @(posedge ref_clk)
    begin
        if (reset || !function_select_button_on)
            function_select_button_hold_r <= 17'h00000;
        else if (tick && function_select_button_hold_r != 17'h1FFFF)
            function_select_button_hold_r <= function_select_button_hold_r + 17'h00001;
        if (reset || function_select_button_edge)
            function_select_button_used_r <= 1'b0;
        else if (exit_hit || hold_reset)
            function_select_button_used_r <= 1'b1;
        function_select_button_rep_r <= reset ? 8'h00 : function_select_button_rep_nxt[7:0];
        ud_rep_r <= reset ? 8'h00 : ud_rep_nxt[7:0];
    end
    assign exit_hit = (state_r == fpsm_pkg::ST_PROG) && function_select_button_on && tick &&
                      function_select_button_hold_r == 17'(fpsm_pkg::EXIT_TICKS - 1);
    assign hold_reset = (state_r == fpsm_pkg::ST_NORMAL) && function_select_button_on && !all3 && tick &&
                        function_select_button_hold_r == 17'(fpsm_pkg::RESET_TICKS - 1);
    assign function_select_button_rep_nxt = rep_next(function_select_button_on, function_select_button_edge, tick, function_select_button_rep_r);
    assign ud_rep_nxt = rep_next(btn_s_r[1] ^ btn_s_r[2], (btn_s_r[2:1] & ~btn_q_r[2:1]) != 2'h0, tick, ud_rep_r);
    assign adv = (state_r == fpsm_pkg::ST_PROG) && !all3 && (function_select_button_edge || function_select_button_rep_nxt[8]);
    assign up_step = (state_r == fpsm_pkg::ST_PROG) && !function_select_button_on && !btn_s_r[2] &&
                     ((btn_s_r[1] && !btn_q_r[1]) || (btn_s_r[1] && ud_rep_nxt[8]));
    assign dn_step = (state_r == fpsm_pkg::ST_PROG) && !function_select_button_on && !btn_s_r[1] &&
                     ((btn_s_r[2] && !btn_q_r[2]) || (btn_s_r[2] && ud_rep_nxt[8]));
    assign restore_fire = (state_r == fpsm_pkg::ST_RESTORE) && none_on && count_r == 3'h0;

    // menu state, selected parameter and restore countdown
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= fpsm_pkg::ST_NORMAL;
            param_r <= fpsm_pkg::P_FREQ;
            count_r <= 3'h0;
            step_cnt_r <= 17'h00000;
        end
        else
        begin
            case (state_r)
                fpsm_pkg::ST_NORMAL:
                begin
                    if (all3)
                    begin
                        state_r <= fpsm_pkg::ST_RESTORE;
                        count_r <= fpsm_pkg::COUNT_START;
                        step_cnt_r <= 17'h00000;
                    end
                    else if (function_select_button_rel && !function_select_button_used_r)
                    begin
                        state_r <= fpsm_pkg::ST_PROG;
                        param_r <= fpsm_pkg::P_FREQ;
                    end
                end
                fpsm_pkg::ST_PROG:
                begin
                    if (all3)
                    begin
                        state_r <= fpsm_pkg::ST_RESTORE;
                        count_r <= fpsm_pkg::COUNT_START;
                        step_cnt_r <= 17'h00000;
                    end
                    else if (exit_hit)
                        state_r <= fpsm_pkg::ST_NORMAL;
                    else if (adv && param_r == fpsm_pkg::P_OPT3)
                        param_r <= fpsm_pkg::P_FREQ;
                    else if (adv)
                        param_r <= fpsm_pkg::fpsm_param_e'(param_r + 3'h1);
                end
                fpsm_pkg::ST_RESTORE:
                begin
                    // releasing all buttons ends it, loading defaults only at zero
                    if (none_on)
                        state_r <= fpsm_pkg::ST_NORMAL;
                    else if (tick && step_cnt_r == 17'(fpsm_pkg::STEP_TICKS - 1))
                    begin
                        step_cnt_r <= 17'h00000;
                        if (count_r != 3'h0)
                            count_r <= count_r - 3'h1;
                    end
                    else if (tick)
                        step_cnt_r <= step_cnt_r + 17'h00001;
                end
                default:
                    state_r <= fpsm_pkg::ST_NORMAL;
            endcase
        end
    end

    assign opt2_expire = set_r.opt2 && tick && opt2_cnt_r == 17'(OPT2_TICKS - 1);
    // next settings: edits apply at once; detection sees mode and delay changes only after the zone empties or a reset
    always_comb
    begin
        set_nxt = set_r;
        if (opt2_expire)
            set_nxt.opt2 = 1'b0;
        if (restore_fire)
            set_nxt = fpsm_pkg::SET_DEF;
        else if (up_step || dn_step)
        begin
            case (param_r)
                fpsm_pkg::P_FREQ:
                    if (up_step && set_r.freq != fpsm_pkg::FREQ_MAX)
                        set_nxt.freq = set_r.freq + 4'h1;
                    else if (dn_step && set_r.freq != fpsm_pkg::FREQ_MIN)
                        set_nxt.freq = set_r.freq - 4'h1;
                fpsm_pkg::P_SENS:
                    if (up_step && set_r.sens != fpsm_pkg::SENS_CALL)
                        set_nxt.sens = set_r.sens + 4'h1;
                    else if (dn_step && set_r.sens != fpsm_pkg::SENS_OFF)
                        set_nxt.sens = set_r.sens - 4'h1;
                fpsm_pkg::P_MODE:
                    set_nxt.pulse_mode = up_step;
                fpsm_pkg::P_DELAY:
                    if (up_step && set_r.delay_s != fpsm_pkg::DELAY_MAX)
                        set_nxt.delay_s = set_r.delay_s + 8'h01;
                    else if (dn_step && set_r.delay_s != 8'h00)
                        set_nxt.delay_s = set_r.delay_s - 8'h01;
                fpsm_pkg::P_EOG:
                    set_nxt.end_of_green_hold = up_step;
                fpsm_pkg::P_OPT1:
                    set_nxt.opt1 = up_step;
                fpsm_pkg::P_OPT2:
                    set_nxt.opt2 = up_step;
                fpsm_pkg::P_OPT3:
                    set_nxt.opt3 = up_step;
                default:
                    set_nxt = set_r;
            endcase
        end
    end

    // settings, deferred mode and delay, option timeout
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            set_r <= fpsm_pkg::SET_DEF;
            mode_eff_r <= fpsm_pkg::SET_DEF.pulse_mode;
            delay_eff_r <= fpsm_pkg::SET_DEF.delay_s;
            opt2_cnt_r <= 17'h00000;
        end
        else
        begin
            set_r <= set_nxt;
            // a vehicle in the zone keeps the mode and delay it arrived under
            if (det_reset_r || !zone_occupied)
            begin
                mode_eff_r <= set_r.pulse_mode;
                delay_eff_r <= set_r.delay_s;
            end
            if (!set_r.opt2 || opt2_expire)
                opt2_cnt_r <= 17'h00000;
            else if (tick)
                opt2_cnt_r <= opt2_cnt_r + 17'h00001;
        end
    end

    // detector reset pulse; menu editing never stops detection itself
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            det_reset_r <= 1'b0;
        else
            det_reset_r <= hold_reset || restore_fire || sw_reset_r ||
                           set_nxt.freq != set_r.freq || set_nxt.sens != set_r.sens;
    end

    // display contents for the selected screen
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            disp_r <= '0;
        else
        begin
            disp_r.prog <= (state_r == fpsm_pkg::ST_PROG);
            disp_r.param <= param_r;
            disp_r.seg_blank <= 1'b0;
            disp_r.seg_val <= 16'h0000;
            disp_r.bar <= 8'h00;
            if (state_r == fpsm_pkg::ST_RESTORE)
                disp_r.seg_val <= {13'h0000, count_r};
            else if (state_r != fpsm_pkg::ST_PROG)
                disp_r.seg_blank <= 1'b1;
            else
            begin
                case (param_r)
                    fpsm_pkg::P_FREQ:
                    begin
                        disp_r.seg_val <= freq_meas_bcd;
                        disp_r.bar <= 8'(8'h01 << (set_r.freq - 4'h1));
                    end
                    fpsm_pkg::P_SENS:
                    begin
                        disp_r.seg_val <= {12'h000, set_r.sens};
                        disp_r.bar <= call_strength;
                    end
                    fpsm_pkg::P_DELAY:
                        disp_r.seg_val <= {8'h00, set_r.delay_s};
                    fpsm_pkg::P_OPT1:
                        disp_r.seg_val <= 16'h0001;
                    fpsm_pkg::P_OPT2:
                        disp_r.seg_val <= 16'h0002;
                    fpsm_pkg::P_OPT3:
                        disp_r.seg_val <= 16'h0003;
                    default:
                        disp_r.seg_blank <= 1'b1;
                endcase
            end
        end
    end

    // apb slave: zero wait states, read data captured in the setup cycle
    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign addr_ok = apb_req.paddr == fpsm_pkg::ADDR_CTRL || apb_req.paddr == fpsm_pkg::ADDR_SET ||
                     apb_req.paddr == fpsm_pkg::ADDR_MENU;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prdata_r <= 32'h00000000;
            sw_reset_r <= 1'b0;
        end
        else
        begin
            sw_reset_r <= apb_wr && apb_req.paddr == fpsm_pkg::ADDR_CTRL &&
                          apb_req.pwdata[fpsm_pkg::CTRL_RESET_BIT];
            if (apb_req.psel && !apb_req.penable)
            begin
                case (apb_req.paddr)
                    fpsm_pkg::ADDR_SET:
                        prdata_r <= {11'h000, live_set};
                    fpsm_pkg::ADDR_MENU:
                        prdata_r <= {24'h000000, state_r, param_r, count_r};
                    default:
                        prdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    assign apb_rsp.prdata = prdata_r;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
    assign live_set = '{freq: set_r.freq, sens: set_r.sens, pulse_mode: mode_eff_r, delay_s: delay_eff_r,
                        end_of_green_hold: set_r.end_of_green_hold, opt1: set_r.opt1, opt2: set_r.opt2, opt3: set_r.opt3};
    assign det_reset = det_reset_r;
    assign disp = disp_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_RESTORE_START: assert property (state_r == fpsm_pkg::ST_NORMAL && all3 |=>
        state_r == fpsm_pkg::ST_RESTORE && count_r == 3'h5) else $error("countdown did not start at five");
    AST_RESTORE_LOAD: assert property (restore_fire |=> set_r == fpsm_pkg::SET_DEF && det_reset_r)
        else $error("defaults not loaded with reset");
    AST_PROG_ENTER: assert property (state_r == fpsm_pkg::ST_NORMAL && !all3 && function_select_button_rel && !function_select_button_used_r
        |=> state_r == fpsm_pkg::ST_PROG && param_r == fpsm_pkg::P_FREQ) else $error("program entry missed");
    AST_WRAP: assert property (adv && !exit_hit && param_r == fpsm_pkg::P_OPT3 |=>
        param_r == fpsm_pkg::P_FREQ) else $error("menu did not wrap");
    AST_EXIT: assert property (exit_hit && !all3 |=> state_r == fpsm_pkg::ST_NORMAL ##1
        state_r == fpsm_pkg::ST_NORMAL) else $error("hold exit failed");
    AST_MODE_HOLD: assert property (zone_occupied && !det_reset_r |=> $stable(mode_eff_r) &&
        $stable(delay_eff_r)) else $error("deferred value changed in occupied zone");
    AST_DELAY_FOLLOW: assert property (!zone_occupied [*2] |=> delay_eff_r == $past(set_r.delay_s) &&
        mode_eff_r == $past(set_r.pulse_mode)) else $error("live value not taken with empty zone");
    AST_OPT2_OFF: assert property (opt2_expire && !(up_step || dn_step) |=> !set_r.opt2)
        else $error("option did not time out");
    AST_SENS_RESET: assert property (set_nxt.sens != set_r.sens |=> det_reset_r ##1 !det_reset_r ||
        $past(sw_reset_r) || restore_fire) else $error("sensitivity change gave no reset");
    AST_FREQ_RANGE: assert property (set_r.freq >= 4'h1 && set_r.freq <= 4'h8 && set_r.sens <= 4'hA)
        else $error("setting out of range");
    COV_RESTORE: cover property (restore_fire);
    COV_WRAP: cover property (adv && param_r == fpsm_pkg::P_OPT3);
    COV_DEFER: cover property (zone_occupied && set_r.delay_s != delay_eff_r);
    COV_HOLD_RESET: cover property (hold_reset);
endmodule : fpsm_top

// *** tb/fpsm_panel.sv ***
// pushbutton front panel model driving the three button contacts
`timescale 1ns/10ps
module fpsm_panel (
    input wire logic ref_clk,            // panel clock
    input wire logic [2:0] hold_mask,    // held buttons: function_select_button, up, down
    output logic btn_function_select_button_pin = 1'b0,    // function-select contact
    output logic btn_up_pin = 1'b0,      // up contact
    output logic btn_down_pin = 1'b0     // down contact
);
    // contacts move just after an edge; no bounce, so only the synchroniser is exercised
    always @(posedge ref_clk)
    begin
        btn_function_select_button_pin <= hold_mask[0];
        btn_up_pin <= hold_mask[1];
        btn_down_pin <= hold_mask[2];
    end
endmodule : fpsm_panel

// *** tb/fpsm_top_bench.sv ***
// self-checking bench of the front-panel settings menu
`timescale 1ns/10ps
module fpsm_top_bench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    fpsm_pkg::fpsm_apb_req_s req = '0;
    fpsm_pkg::fpsm_apb_rsp_s rsp;
    fpsm_pkg::fpsm_set_s live;
    fpsm_pkg::fpsm_disp_s disp;
    logic [2:0] hold_mask = 3'h0;
    logic btn_f, btn_u, btn_d, det_reset;
    logic zone = 1'b0;
    logic [7:0] strength = 8'h00;
    logic [15:0] fbcd = 16'h0000;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int checks_done = 0;
    int det_n = 0;
    int d0;
    int m_freq = 2;
    int seed = 32'hDD8B;

    // clock at 50 ns period
    initial
        forever #25 ref_clk = ~ref_clk;

    fpsm_panel panel (.ref_clk(ref_clk), .hold_mask(hold_mask), .btn_function_select_button_pin(btn_f),
        .btn_up_pin(btn_u), .btn_down_pin(btn_d));

    // short tick and timeout keep the run near 10000 cycles
    fpsm_top #(.TICK_CYC(10), .OPT2_TICKS(5)) uut (.ref_clk(ref_clk), .reset(reset), .apb_req(req),
        .apb_rsp(rsp), .btn_function_select_button_pin(btn_f), .btn_up_pin(btn_u), .btn_down_pin(btn_d),
        .zone_occupied(zone), .call_strength(strength), .freq_meas_bcd(fbcd), .live_set(live),
        .det_reset(det_reset), .disp(disp));

    // count detector reset pulses
    always @(posedge ref_clk)
        if (det_reset === 1'b1)
            det_n++;

    // model of the settings word as read back over apb
    function automatic logic [31:0] set_word(input int f, input int s);
        return {11'h000, f[3:0], s[3:0], 1'b0, 8'h00, 4'h0};
    endfunction : set_word

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // one apb transfer; held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        while (rsp.pready !== 1'b1)
            @(posedge ref_clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    // hold buttons for n cycles, then let the synchroniser settle
    task automatic press(input logic [2:0] m, input int n);
        hold_mask <= m;
        repeat (n) @(posedge ref_clk);
        hold_mask <= 3'h0;
        repeat (20) @(posedge ref_clk);
    endtask : press

    // watchdog well above the expected run of about 10000 cycles
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, set_word(2, 6));
        apb(1'b0, 8'h0C, 32'h0);
        chk(err, 1);
        fbcd <= 16'($random(seed));
        strength <= 8'($random(seed));
        press(3'h1, 40);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[7:3], 5'h08);
        chk(disp.seg_val, fbcd);
        d0 = det_n;
        press(3'h2, 40);
        m_freq++;
        chk(live.freq, m_freq);
        chk(disp.bar, 1 << (m_freq - 1));
        chk(det_n - d0, 1);
        press(3'h1, 40);
        chk(disp.bar, strength);
        press(3'h4, 500);
        chk(live.sens < 4'h4, 1);
        $display("test navigation done");
        for (int i = 0; i < 2; i++)
        begin
            press(3'h1, 40);
            zone <= 1'b1;
            press(3'h2, 40);
            chk(i ? live.delay_s : live.pulse_mode, 0);
            chk(disp.seg_blank, 1 - i);
            chk(disp.seg_val, i);
            zone <= 1'b0;
            repeat (4) @(posedge ref_clk);
            chk(i ? live.delay_s : live.pulse_mode, 1);
        end
        repeat (3) press(3'h1, 40);
        press(3'h2, 5);
        chk(live.opt2, 1);
        chk(disp.seg_val, 16'h0002);
        repeat (60) @(posedge ref_clk);
        chk(live.opt2, 0);
        repeat (2) press(3'h1, 40);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[5:3], 3'h0);
        $display("test deferral done");
        hold_mask <= 3'h1;
        repeat (1050) @(posedge ref_clk);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[7:6], 2'h0);
        d0 = det_n;
        repeat (2000) @(posedge ref_clk);
        press(3'h0, 1);
        chk(det_n - d0, 1);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[7:6], 2'h0);
        d0 = det_n;
        apb(1'b1, 8'h00, 32'h1);
        repeat (4) @(posedge ref_clk);
        chk(det_n - d0, 1);
        hold_mask <= 3'h7;
        repeat (20) @(posedge ref_clk);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[2:0], 3'h5);
        repeat (5300) @(posedge ref_clk);
        apb(1'b0, 8'h08, 32'h0);
        chk({rd[7:6], rd[2:0]}, 5'h10);
        d0 = det_n;
        press(3'h0, 1);
        chk({11'h000, live}, set_word(2, 6));
        chk(det_n - d0, 1);
        $display("test restore done");
        print_verdict();
    end
endmodule : fpsm_top_bench
